// ### shared/touch_key_pkg.sv
// Shared constants and types for the touch key toggle logic.
package touch_key_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SLEEP_MS = 80;
  localparam longint unsigned SLEEP_CYC = longint'(CLK_HZ) / 1000 * SLEEP_MS;
  localparam int unsigned RECAL_S = 60;
  localparam longint unsigned RECAL_CYC = longint'(CLK_HZ) * RECAL_S;
  localparam int unsigned STRAP_CYC = 16;

  // ------------------------------------------------------------------
  // Signal processing
  // ------------------------------------------------------------------
  localparam int unsigned SIG_W = 16;
  localparam logic [SIG_W-1:0] DETECT_THR = 16'h000a;
  localparam logic [SIG_W-1:0] HYST = 16'h0002;
  localparam logic [2:0] CONFIRM_COUNT = 3'h4;
  localparam logic [SIG_W-1:0] DRIFT_STEP = 16'h0001;
  localparam logic [7:0] DRIFT_DOWN_BURSTS = 8'h02;
  localparam logic [7:0] DRIFT_UP_BURSTS = 8'h10;

  // ------------------------------------------------------------------
  // Spread spectrum: signed per-mille offset, +/-75 is +/-7.5 percent
  // ------------------------------------------------------------------
  localparam logic signed [7:0] SPREAD_MAX = 8'sh4b;
  localparam logic signed [7:0] SPREAD_STEP = 8'sh05;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_STRAP = 5'b00001,
    ST_CAL   = 5'b00010,
    ST_BURST = 5'b00100,
    ST_SLEEP = 5'b01000,
    ST_FAST  = 5'b10000
  } seq_state_e;

endpackage : touch_key_pkg

// ### shared/burst_if.sv
// Burst result channel between the sequencer and the touch detector.
`timescale 1ns/1ps
interface burst_if;
  import touch_key_pkg::*;
  logic done;
  logic [SIG_W-1:0] value;
  logic calibrate;
  logic detect;
  logic confirmed;
  logic rejected;
  logic timeout;
  logic engaged;
  modport seq (output done, value, calibrate,
               input detect, confirmed, rejected, timeout, engaged);
  modport det (input done, value, calibrate,
               output detect, confirmed, rejected, timeout, engaged);
endinterface : burst_if

// ### design/touch_detector.sv
// Threshold detection, confirmation integrator, timeout and drift compensation.
`timescale 1ns/1ps
module touch_detector
  import touch_key_pkg::*;
#(
  parameter longint unsigned RECAL_CYCLES = RECAL_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Burst channel
  burst_if.det bus
);

  logic [SIG_W-1:0] ref_r;
  logic [2:0] confirm_cnt_r;
  logic [7:0] drift_cnt_r;
  logic [35:0] hold_cnt_r;
  logic engaged_r;

  // Threshold and hysteresis are derived from the current reference.
  wire [SIG_W-1:0] delta = (bus.value > ref_r) ? bus.value - ref_r : '0;
  wire [SIG_W-1:0] rel_thr = engaged_r ? DETECT_THR - HYST : DETECT_THR;
  wire hit = bus.done && (delta >= rel_thr);
  wire hit_final = hit && (confirm_cnt_r == CONFIRM_COUNT - 3'h1);
  wire time_up = engaged_r && (hold_cnt_r >= 36'(RECAL_CYCLES));
  wire falling = bus.value < ref_r;
  wire settled = (bus.value == ref_r);
  wire [7:0] drift_lim = falling ? DRIFT_DOWN_BURSTS : DRIFT_UP_BURSTS;
  wire drift_go = bus.done && !hit && !engaged_r && (drift_cnt_r >= drift_lim - 8'h01);

  assign bus.detect = hit;
  assign bus.confirmed = hit_final && !engaged_r;
  assign bus.rejected = bus.done && !hit && (confirm_cnt_r != 3'h0);
  assign bus.timeout = time_up;
  assign bus.engaged = engaged_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_r <= '0;
      confirm_cnt_r <= 3'h0;
      drift_cnt_r <= 8'h00;
      hold_cnt_r <= 36'h0;
      engaged_r <= 1'b0;
    end else if (bus.calibrate || time_up) begin
      if (bus.calibrate) ref_r <= bus.value;
      confirm_cnt_r <= 3'h0;
      drift_cnt_r <= 8'h00;
      hold_cnt_r <= 36'h0;
      engaged_r <= 1'b0;
    end else begin
      if (engaged_r) hold_cnt_r <= hold_cnt_r + 36'h1;
      if (bus.done) begin
        if (!hit) begin
          confirm_cnt_r <= 3'h0;
          engaged_r <= 1'b0;
          hold_cnt_r <= 36'h0;
        end else if (hit_final) begin
          engaged_r <= 1'b1;
        end else if (!engaged_r) begin
          confirm_cnt_r <= confirm_cnt_r + 3'h1;
        end
        // A reference equal to the signal holds still, so it cannot creep above it.
        if (hit || engaged_r || settled) begin
          drift_cnt_r <= 8'h00;
        end else if (drift_go) begin
          drift_cnt_r <= 8'h00;
          ref_r <= falling ? ref_r - DRIFT_STEP : ref_r + DRIFT_STEP;
        end else begin
          drift_cnt_r <= drift_cnt_r + 8'h01;
        end
      end
    end
  end

endmodule : touch_detector

// ### design/touch_key_toggle_logic.sv
// Top level: burst sequencing, output toggle, polarity strap and spread spectrum.
`timescale 1ns/1ps
module touch_key_toggle_logic
  import touch_key_pkg::*;
#(
  parameter longint unsigned SLEEP_CYCLES = SLEEP_CYC,
  parameter longint unsigned RECAL_CYCLES = RECAL_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Charge-transfer front end
  input wire logic i_burst_done,
  input wire logic [SIG_W-1:0] i_burst_value,
  output logic o_burst_start,
  output logic signed [7:0] o_osc_trim,
  // Key output pin
  input wire logic i_key_pin,
  output logic o_key_pin,
  output logic o_key_pin_oe_n,
  // Status
  output logic o_fast_mode
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [31:0] wait_cnt_r;
  logic active_low_r;
  logic key_on_r;
  logic pin_r;
  logic oe_n_r;
  logic start_r;
  logic signed [7:0] trim_r;
  logic trim_up_r;

  burst_if bus ();

  touch_detector #(
    .RECAL_CYCLES(RECAL_CYCLES)
  ) u_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(bus)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  wire in_burst = (state_r == ST_BURST) || (state_r == ST_CAL) || (state_r == ST_FAST);
  wire sleep_done = wait_cnt_r >= 32'(SLEEP_CYCLES - 1);
  wire strap_done = wait_cnt_r >= 32'(STRAP_CYC - 1);
  wire suspect = bus.detect && !bus.confirmed && !bus.engaged;

  assign bus.done = i_burst_done && in_burst;
  assign bus.value = i_burst_value;
  assign bus.calibrate = i_burst_done && (state_r == ST_CAL);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP: if (strap_done) state_nxt = ST_CAL;
      ST_CAL: if (i_burst_done) state_nxt = ST_SLEEP;
      ST_BURST: if (i_burst_done) state_nxt = suspect ? ST_FAST : ST_SLEEP;
      ST_FAST: if (bus.confirmed || bus.rejected) state_nxt = ST_SLEEP;
      ST_SLEEP: if (sleep_done) state_nxt = ST_BURST;
      default: state_nxt = ST_STRAP;
    endcase
    if (bus.timeout) state_nxt = ST_CAL;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_STRAP;
      wait_cnt_r <= 32'h0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_cnt_r <= (state_nxt != state_r) ? 32'h0 : wait_cnt_r + 32'h1;
      start_r <= (state_nxt != state_r) && (state_nxt != ST_SLEEP)
                 && (state_nxt != ST_STRAP);
    end
  end

  // ------------------------------------------------------------------
  // Polarity strap and output toggle
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_low_r <= 1'b0;
      key_on_r <= 1'b0;
      pin_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      if (state_r == ST_STRAP && strap_done) begin
        active_low_r <= i_key_pin;
        oe_n_r <= 1'b0;
      end
      if (bus.confirmed) key_on_r <= ~key_on_r;
      pin_r <= (bus.confirmed ? ~key_on_r : key_on_r) ^
               ((state_r == ST_STRAP) ? i_key_pin : active_low_r);
    end
  end

  // ------------------------------------------------------------------
  // Spread spectrum trim, a triangle sweep while a burst runs
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trim_r <= 8'sh00;
      trim_up_r <= 1'b1;
    end else if (!in_burst) begin
      trim_r <= 8'sh00;
      trim_up_r <= 1'b1;
    end else if (trim_up_r) begin
      trim_r <= trim_r + SPREAD_STEP;
      if (trim_r + SPREAD_STEP >= SPREAD_MAX) trim_up_r <= 1'b0;
    end else begin
      trim_r <= trim_r - SPREAD_STEP;
      if (trim_r - SPREAD_STEP <= -SPREAD_MAX) trim_up_r <= 1'b1;
    end
  end

  assign o_burst_start = start_r;
  assign o_osc_trim = trim_r;
  assign o_key_pin = pin_r;
  assign o_key_pin_oe_n = oe_n_r;
  assign o_fast_mode = (state_r == ST_FAST);

endmodule : touch_key_toggle_logic

// ### tb/front_end_model.sv
// Behavioural front end, electrode and strap resistor.
`timescale 1ns/1ps
module front_end_model
  import touch_key_pkg::*;
(
  // Bench controls
  input wire logic i_clk,
  input wire logic [SIG_W-1:0] i_level,
  input wire logic i_strap,
  // Block side
  input wire logic i_start,
  input wire logic i_fast,
  input wire logic i_pin,
  input wire logic i_oe_n,
  output logic o_done,
  output logic [SIG_W-1:0] o_value,
  output logic o_pin
);
  logic [3:0] cnt_r;
  initial begin
    cnt_r = 4'h0;
    o_done = 1'b0;
  end
  // The count is only valid with done; otherwise the line shows a changed pattern.
  assign o_value = o_done ? i_level : ~i_level;
  assign o_pin = i_oe_n ? i_strap : i_pin;
  always @(posedge i_clk) begin
    o_done <= (cnt_r == 4'h1);
    if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    else if (i_start || (i_fast && !o_done)) cnt_r <= 4'h8;
  end
endmodule : front_end_model

// ### tb/touch_key_chk.sv
// Assertions on the ports of the touch key toggle logic.
`timescale 1ns/1ps
module touch_key_chk
  import touch_key_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_burst_done,
  input wire logic o_burst_start,
  input wire logic signed [7:0] o_osc_trim,
  input wire logic o_key_pin,
  input wire logic o_key_pin_oe_n,
  input wire logic o_fast_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_start_one_cycle: assert property (o_burst_start |=> !o_burst_start)
    else $error("burst start longer than one cycle");
  a_sleep_gap: assert property ((i_burst_done && !o_fast_mode ##1 !o_fast_mode) |-> !o_burst_start [*8])
    else $error("burst started without sleep gap");
  a_trim_range: assert property (o_osc_trim <= SPREAD_MAX && o_osc_trim >= -SPREAD_MAX)
    else $error("oscillator trim out of range");
  a_fast_entry: assert property ($rose(o_fast_mode) |-> o_burst_start && $past(i_burst_done))
    else $error("fast mode entered without burst result");
  a_fast_hold: assert property (o_fast_mode && !i_burst_done |=> o_fast_mode)
    else $error("fast mode left without burst result");
  a_toggle_cause: assert property ($changed(o_key_pin) && !$past(o_key_pin_oe_n) |-> $past(i_burst_done) && $past(o_fast_mode))
    else $error("key pin changed without confirmed touch");
  a_strap_phase: assert property ($rose(i_rst_n) |-> o_key_pin_oe_n [*8])
    else $error("key pin driven during strap phase");
  a_drive_kept: assert property (!o_key_pin_oe_n |=> !o_key_pin_oe_n)
    else $error("key pin drive released");
endmodule : touch_key_chk
bind touch_key_toggle_logic touch_key_chk touch_key_chk_i (.i_clk, .i_rst_n, .i_burst_done,
  .o_burst_start, .o_osc_trim, .o_key_pin, .o_key_pin_oe_n, .o_fast_mode);

// ### tb/tb.sv
// Self-checking testbench for the touch key toggle logic.
`timescale 1ns/1ps
module tb;
  import touch_key_pkg::*;
  logic clk, rst_n, strap, start, fast, pin, pin_o, oe_n, done;
  logic [SIG_W-1:0] level, value;
  logic signed [7:0] trim;
  int n_fail = 0;
  int compares = 0;
  localparam logic [SIG_W-1:0] BASE = 16'h0100;
  localparam longint unsigned SLEEP_SHORT = 50;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  touch_key_toggle_logic #(.SLEEP_CYCLES(SLEEP_SHORT), .RECAL_CYCLES(2000))
    touch_key_toggle_logic_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_burst_done(done), .i_burst_value(value),
    .o_burst_start(start), .o_osc_trim(trim), .i_key_pin(pin), .o_key_pin(pin_o),
    .o_key_pin_oe_n(oe_n), .o_fast_mode(fast));
  front_end_model front_end_model_i (.i_clk(clk), .i_level(level), .i_strap(strap),
    .i_start(start), .i_fast(fast), .i_pin(pin_o), .i_oe_n(oe_n), .o_done(done),
    .o_value(value), .o_pin(pin));
  task automatic chk(input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Waits for n burst results, then lets the block react.
  task automatic bursts(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      @(negedge clk);
      while (!done && t < 300) begin
        @(negedge clk);
        t++;
      end
      if (t == 300) begin
        n_fail++;
        end_of_test();
      end
    end
    repeat (2) @(negedge clk);
  endtask : bursts
  task automatic setl(input logic [SIG_W-1:0] v);
    @(posedge clk);
    level <= v;
  endtask : setl
  task automatic power_up(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    level <= BASE;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bursts(1);
    chk(s, pin_o);
    chk(1'b0, oe_n);
  endtask : power_up
  task automatic press(input logic [SIG_W-1:0] v, input logic exp);
    setl(v);
    bursts(3);
    chk(~exp, pin_o);
    chk(1'b1, fast);
    bursts(1);
    chk(exp, pin_o);
    chk(1'b0, fast);
  endtask : press
  // Called right after a burst result: measures the sleep gap and the first trim step.
  task automatic sc_spread();
    int t;
    t = 0;
    chk(1'b1, trim == 8'sh00);
    while (!start && t < 300) begin
      @(negedge clk);
      t++;
    end
    chk(1'b1, t == SLEEP_SHORT - 1);
    @(negedge clk);
    chk(1'b1, trim == SPREAD_STEP);
    bursts(1);
    chk(1'b1, trim == 8'sh00);
  endtask : sc_spread
  // The reference falls toward a lower level, so a smaller level is then enough for a touch.
  task automatic sc_drift();
    setl(BASE + 16'h0007);
    bursts(8);
    press(BASE + 16'h0011, 1'b0);
  endtask : sc_drift
  task automatic sc_below();
    setl(BASE + 16'h0009);
    bursts(1);
    chk(1'b0, fast);
    setl(BASE);
    bursts(1);
  endtask : sc_below
  task automatic sc_reject();
    setl(BASE + 16'h000a);
    bursts(3);
    chk(1'b1, fast);
    setl(BASE);
    bursts(1);
    chk(1'b0, fast);
    setl(BASE + 16'h000a);
    bursts(1);
    setl(BASE);
    bursts(1);
    chk(1'b0, pin_o);
  endtask : sc_reject
  task automatic sc_release(input logic exp);
    press(BASE + 16'h000a, exp);
    setl(BASE);
    bursts(2);
    chk(exp, pin_o);
  endtask : sc_release
  task automatic sc_timeout();
    press(BASE + 16'h000a, 1'b0);
    repeat (2300) @(posedge clk);
    chk(1'b0, pin_o);
    press(BASE + 16'h0014, 1'b1);
  endtask : sc_timeout
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    level = BASE;
    power_up(1'b0);
    sc_spread();
    sc_below();
    sc_reject();
    sc_release(1'b1);
    sc_release(1'b0);
    power_up(1'b1);
    sc_release(1'b0);
    sc_release(1'b1);
    sc_timeout();
    sc_drift();
    end_of_test();
  end
endmodule : tb
